// ===== bench/motor_side.sv
`timescale 1ns/1ps
// ==========
// axis model: position, switches, encoder index, offset move
module motor_side
    import homing_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire motion_t motion,
    input wire logic offsetMoveStart,
    input wire logic homeBlocked,
    output logic homeSw,
    output logic zPulse,
    output logic posLim,
    output logic negLim,
    output logic offsetMoveDone
);
    logic signed [15:0] axisPos_q;
    logic [3:0] moveCnt_q;
    // blocked stands for a dead switch and encoder, so a search can only time out or run into a limit
    assign homeSw = !homeBlocked && (axisPos_q >= 16'sd40);
    assign zPulse = !homeBlocked && motion.active && (axisPos_q[3:0] == 4'h0);
    assign posLim = axisPos_q >= 16'sd25000;
    assign negLim = axisPos_q <= -16'sd25000;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            axisPos_q <= '0;
            moveCnt_q <= '0;
            offsetMoveDone <= 1'b0;
        end else begin
            if (motion.active) begin
                axisPos_q <= motion.dirForward ? axisPos_q + 16'sd1 : axisPos_q - 16'sd1;
            end
            // the offset move takes a few cycles, never zero
            if (offsetMoveStart) begin
                moveCnt_q <= 4'h5;
            end else if (moveCnt_q != 4'h0) begin
                moveCnt_q <= moveCnt_q - 4'h1;
            end
            offsetMoveDone <= (moveCnt_q == 4'h1);
        end
    end
endmodule

// ===== bench/tb.sv
`timescale 1ns/1ps
module tb
    import homing_pkg::*;
;
    logic sys_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, positionCount, offsetMoveDist, v;
    logic pready, pslverr, positionLoad, offsetMoveStart, interruptStart, interruptLocked, stageWaitDone;
    logic homingComplete, z_pulse_missing_alarm, homing_timeout_alarm, homeSw, zPulse, posLim, negLim;
    logic startIn = 1'b0, trigIn = 1'b0, unlockIn = 1'b0, panelStart = 1'b0, offsetMoveDone;
    logic interruptMoveDone = 1'b0, homeBlocked = 1'b0, moved = 1'b0, stageDone = 1'b0;
    logic [15:0] slowRpm = '0;
    sense_t sense;
    motion_t motion;
    int errors = 0, checks = 0, cycles = 0, intCnt = 0, waitCnt = 0, loadCnt = 0, n;
    logic [31:0] rstTab [13] = '{32'h0000_00C8, 32'h0000_000A, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
        32'h0000_0002, 32'h0000_0002, 32'h0000_01F4, 32'h0000_0032, 32'h0000_01F4, 32'h0000_EA60,
        32'h0000_0000, 32'h0000_0000};
    assign sense = {posLim, negLim, homeSw, zPulse, startIn, trigIn, unlockIn};
    homing_ctrl dut (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sense(sense), .panelStart(panelStart), .offsetMoveDone(offsetMoveDone),
        .interruptMoveDone(interruptMoveDone), .stageDone(stageDone), .motion(motion), .positionCount(positionCount),
        .positionLoad(positionLoad), .offsetMoveDist(offsetMoveDist), .offsetMoveStart(offsetMoveStart),
        .interruptStart(interruptStart), .interruptLocked(interruptLocked), .stageWaitDone(stageWaitDone),
        .homingComplete(homingComplete), .z_pulse_missing_alarm(z_pulse_missing_alarm),
        .homing_timeout_alarm(homing_timeout_alarm));
    motor_side axis (.sys_clk(sys_clk), .rst_n(rst_n), .motion(motion), .offsetMoveStart(offsetMoveStart),
        .homeBlocked(homeBlocked), .homeSw(homeSw), .zPulse(zPulse), .posLim(posLim), .negLim(negLim),
        .offsetMoveDone(offsetMoveDone));
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    // ==========
    // bus and check helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        v = prdata;
        n = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // one-cycle strobe launched at a rising edge; a selector, since strobes cannot be passed by reference
    task automatic pulse(input int sel);
        @(posedge sys_clk);
        case (sel)
            0: interruptMoveDone <= 1'b1;
            1: unlockIn <= 1'b1;
            2: startIn <= 1'b1;
            3: panelStart <= 1'b1;
            default: stageDone <= 1'b1;
        endcase
        @(posedge sys_clk);
        {interruptMoveDone, unlockIn, startIn, panelStart, stageDone} <= '0;
    endtask
    task automatic doReset();
        rst_n <= 1'b0;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
    endtask
    task automatic waitDone();
        for (int i = 0; i < 300 && homingComplete !== 1'b1; i++) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (interruptStart === 1'b1) intCnt++;
        if (motion.active === 1'b1 && homeSw) slowRpm = motion.speedRpm;
        if (motion.active === 1'b1) moved = 1'b1;
        if (stageWaitDone === 1'b1) waitCnt++;
        if (positionLoad === 1'b1) loadCnt++;
        if (cycles == 90000) begin
            errors++;
            close_out();
        end
    end
    // ==========
    // tests
    initial begin
        doReset();
        for (int i = 0; i < 13; i++) begin
            apb(1'b0, 8'(4 * i), '0);
            chk(v, rstTab[i]);
        end
        apb(1'b1, OFS_SLOW, 32'h0000_0064);
        apb(1'b0, OFS_SLOW, '0);
        chk(v, 32'h0000_0064);
        apb(1'b0, 8'h40, '0);
        chk(32'(n), 32'h0000_0001);
        $display("registers done");
        for (int s = 0; s < 5; s++) begin
            apb(1'b1, OFS_INTP_SEL, 32'(s));
            apb(1'b1, OFS_CTRL, 32'h0000_0004);
            intCnt = 0;
            trigIn <= 1'b1;
            repeat (4) @(posedge sys_clk);
            chk(32'(intCnt), 32'(s == 1 || s == 2));
            trigIn <= 1'b0;
            repeat (4) @(posedge sys_clk);
            chk(32'(intCnt), 32'(s != 0));
            pulse(0);
            repeat (3) @(negedge sys_clk);
            chk(32'(interruptLocked), 32'(s == 2 || s == 4));
            pulse(1);
            repeat (3) @(negedge sys_clk);
            chk(32'(interruptLocked), 32'h0000_0000);
        end
        $display("interrupt done");
        doReset();
        apb(1'b1, OFS_HOME_SRC, 32'h0000_0003);
        apb(1'b1, OFS_ORG_OFS, 32'h0000_1234);
        apb(1'b1, OFS_MECH_OFS, 32'hFFFF_FFF0);
        apb(1'b1, OFS_SLOW, 32'h0000_0064);
        apb(1'b1, OFS_CTRL, 32'h0000_0004);
        apb(1'b1, OFS_CTRL, 32'h0000_0001);
        for (int i = 0; i < 5 && motion.active !== 1'b1; i++) @(negedge sys_clk);
        chk({motion.active, motion.dirForward, motion.speedRpm}, {2'b11, 16'h01F4});
        chk(32'(motion.rampMs), 32'h0000_01F4);
        waitDone();
        chk(positionCount, 32'h0000_1234);
        chk(offsetMoveDist, 32'hFFFF_FFF0);
        chk(32'(slowRpm), 32'h0000_0064);
        chk(32'(homingComplete), 32'h0000_0001);
        apb(1'b1, OFS_CTRL, 32'h0000_0001);
        repeat (3) @(negedge sys_clk);
        chk(32'(homingComplete), 32'h0000_0000);
        $display("homing done");
        doReset();
        homeBlocked <= 1'b1;
        apb(1'b1, OFS_HOME_SRC, 32'h0000_0001);
        apb(1'b1, OFS_TMO, 32'h0000_0001);
        apb(1'b1, OFS_CTRL, 32'h0000_0004);
        pulse(2);
        for (n = 0; n < 45000 && homing_timeout_alarm !== 1'b1; n++) @(posedge sys_clk);
        chk(32'(n >= CYC_PER_MS - 4 && n <= 2 * CYC_PER_MS), 32'h0000_0001);
        @(negedge sys_clk);
        chk(32'(motion.active), 32'h0000_0000);
        // restart from the fault: the axis runs on into the positive limit with the switch dead
        apb(1'b1, OFS_LIMZ, 32'h0000_0005);
        apb(1'b1, OFS_TMO, 32'h0000_EA60);
        apb(1'b1, OFS_CTRL, 32'h0000_0004);
        pulse(2);
        for (n = 0; n < 8000 && z_pulse_missing_alarm !== 1'b1; n++) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(32'({z_pulse_missing_alarm, homing_timeout_alarm, motion.active}), 32'h0000_0004);
        $display("timeout done");
        doReset();
        homeBlocked <= 1'b0;
        apb(1'b1, OFS_HOME_SRC, 32'h0000_0002);
        apb(1'b1, OFS_HOME_MODE, 32'h0000_0008);
        apb(1'b1, OFS_ORG_OFS, 32'h0000_0055);
        apb(1'b1, OFS_CTRL, 32'h0000_0004);
        moved = 1'b0;
        loadCnt = 0;
        pulse(3);
        waitDone();
        chk(positionCount, 32'h0000_0055);
        chk(32'(moved), 32'h0000_0000);
        apb(1'b1, OFS_HOME_SRC, 32'h0000_0004);
        apb(1'b1, OFS_CTRL, 32'h0000_0006);
        repeat (3) @(posedge sys_clk);
        waitDone();
        chk(32'(loadCnt), 32'h0000_0002);
        chk(32'(homingComplete), 32'h0000_0001);
        pulse(4);
        repeat (4) @(posedge sys_clk);
        chk(32'(waitCnt), 32'h0000_0001);
        $display("present position done");
        close_out();
    end
endmodule

// ===== core/homing_ctrl.sv
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
// Operation
// - setting 0 disables interrupt positioning completely
// - settings 1,2 trigger on rising edge; 3,4 on falling edge
// - settings 1,3 unlock on completion; 2,4 wait for unlock input
// - start source: off, digital input, panel, communication, first servo-on
// - modes 0/1 search forward/backward, limit switch is origin
// - modes 2,3 home switch rising; modes 4,5 falling; fwd/back
// - modes 6/7 move forward/backward to nearest Z pulse
// - mode 8 takes present position, no motion; mode default 2
// - after limit: 0 reverse to Z, 1 forward to Z, 2 no Z; default 2
// - settings 3-5 act as 0-2 plus stop and Z-missing alarm on limit
// - modes 0/1: limit contact never stops or alarms
// - modes 2-5: Z search begins after home switch contact
// - homing starts at high search speed, default 500
// - after contacting origin/switch, continue at low speed, default 50
// - ramp start/stop of search over programmed time, default 500
// - homing run timed in 1 ms steps, default limit 60000
// - timeout without origin raises timeout alarm and stops
// - origin found loads position counter with coordinate offset
// - after origin, move on by mechanical offset distance
// - stage 16 runs at programmed max speed, default 200
// - stage 16 ramp time default 10; wait after stage default 0
module homing_ctrl
    import homing_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [REG_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire sense_t sense,
    input wire logic panelStart,
    input wire logic offsetMoveDone,
    input wire logic interruptMoveDone,
    input wire logic stageDone,
    output motion_t motion,
    output logic [31:0] positionCount,
    output logic positionLoad,
    output logic [31:0] offsetMoveDist,
    output logic offsetMoveStart,
    output logic interruptStart,
    output logic interruptLocked,
    output logic stageWaitDone,
    output logic homingComplete,
    output logic z_pulse_missing_alarm,
    output logic homing_timeout_alarm
);
    // ==========================================
    // register file
    logic [15:0] stgSpeed_q, stgRamp_q, stgWait_q, fast_q, slow_q, ramp_q, tmo_q;
    logic [31:0] orgOfs_q, mechOfs_q;
    latched_t pend_q, act_q;
    logic servoOn_q, commStart_q;
    wire wrEn = psel && penable && pwrite && clkEn;
    wire rdAcc = psel && penable && !pwrite;
    function automatic logic hit(input logic [REG_AW-1:0] a, input logic [REG_AW-1:0] ofs);
        hit = (a == ofs);
    endfunction
    wire mapped = (paddr <= OFS_POS) && (paddr[1:0] == 2'b00);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    wire restartPulse = wrEn && hit(paddr, OFS_CTRL) && pwdata[CTRL_RESTART_BIT];
    wire startPulseComm = wrEn && hit(paddr, OFS_CTRL) && pwdata[CTRL_START_BIT];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stgSpeed_q <= RST_STG_SPEED; stgRamp_q <= RST_STG_RAMP; stgWait_q <= RST_STG_WAIT;
            fast_q <= RST_FAST; slow_q <= RST_SLOW; ramp_q <= RST_RAMP; tmo_q <= RST_TMO;
            orgOfs_q <= '0; mechOfs_q <= '0; servoOn_q <= 1'b0;
            pend_q <= '{RST_INTP_SEL[3:0], RST_HOME_SRC[3:0], RST_HOME_MODE[3:0], RST_LIMZ[3:0]};
            act_q <= '{RST_INTP_SEL[3:0], RST_HOME_SRC[3:0], RST_HOME_MODE[3:0], RST_LIMZ[3:0]};
        end else if (wrEn) begin
            // speeds, times and offsets take effect at once
            if (hit(paddr, OFS_STG_SPEED)) stgSpeed_q <= pwdata[15:0];
            if (hit(paddr, OFS_STG_RAMP)) stgRamp_q <= pwdata[15:0];
            if (hit(paddr, OFS_STG_WAIT)) stgWait_q <= pwdata[15:0];
            if (hit(paddr, OFS_FAST)) fast_q <= pwdata[15:0];
            if (hit(paddr, OFS_SLOW)) slow_q <= pwdata[15:0];
            if (hit(paddr, OFS_RAMP)) ramp_q <= pwdata[15:0];
            if (hit(paddr, OFS_TMO)) tmo_q <= pwdata[15:0];
            if (hit(paddr, OFS_ORG_OFS)) orgOfs_q <= pwdata;
            if (hit(paddr, OFS_MECH_OFS)) mechOfs_q <= pwdata;
            if (hit(paddr, OFS_INTP_SEL)) pend_q.intpSel <= pwdata[3:0];
            if (hit(paddr, OFS_HOME_SRC)) pend_q.homeSrc <= pwdata[3:0];
            if (hit(paddr, OFS_HOME_MODE)) pend_q.homeMode <= pwdata[3:0];
            if (hit(paddr, OFS_LIMZ)) pend_q.limZ <= pwdata[3:0];
            if (hit(paddr, OFS_CTRL)) servoOn_q <= pwdata[CTRL_SERVO_BIT];
            if (restartPulse) act_q <= pend_q;
        end
    end

    // ==========================================
    // input edges
    sense_t sense_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) sense_q <= '0;
        else if (clkEn) sense_q <= sense;
    end
    wire homeRise = sense.homeSwitch && !sense_q.homeSwitch;
    wire homeFall = !sense.homeSwitch && sense_q.homeSwitch;
    wire zRise = sense.zPulse && !sense_q.zPulse;
    wire trigRise = sense.interruptTrigInput && !sense_q.interruptTrigInput;
    wire trigFall = !sense.interruptTrigInput && sense_q.interruptTrigInput;
    wire stRise = sense.homingStartInput && !sense_q.homingStartInput;

    // ==========================================
    // homing sequencer
    typedef enum logic [6:0] {
        S_IDLE = 7'b000_0001, S_SEEK = 7'b000_0010, S_ZSEEK = 7'b000_0100,
        S_OFFSET = 7'b000_1000, S_DONE = 7'b001_0000, S_FAULT = 7'b010_0000,
        S_SLOWAPP = 7'b100_0000
    } state_t;
    state_t state_q, state_d;
    logic dir_q, dir_d, firstServo_q;
    logic [15:0] msCnt_q;
    logic msTick;
    wire [3:0] mode = act_q.homeMode;
    wire [3:0] limZ = act_q.limZ;
    wire limZBase = (limZ >= LIMZ_ALARM_BASE);
    wire [3:0] zSel = limZBase ? limZ - LIMZ_ALARM_BASE : limZ;
    wire limitMode = (mode <= 4'd1);
    wire switchMode = (mode >= 4'd2) && (mode <= 4'd5);
    wire zMode = (mode == 4'd6) || (mode == 4'd7);
    wire modeFwd = !mode[0];
    wire limitHit = dir_q ? sense.posLimit : sense.negLimit;
    wire switchEdge = (mode <= 4'd3) ? homeRise : homeFall;
    wire autoStart = (act_q.homeSrc == SRC_AUTO) && servoOn_q && !firstServo_q;
    logic startReq;
    always_comb begin
        case (act_q.homeSrc)
            SRC_DI: startReq = stRise;
            SRC_PANEL: startReq = panelStart;
            SRC_COMM: startReq = startPulseComm;
            SRC_AUTO: startReq = autoStart;
            default: startReq = 1'b0;
        endcase
    end
    wire starting = (state_q == S_IDLE || state_q == S_DONE || state_q == S_FAULT) && startReq;
    wire running = (state_q == S_SEEK) || (state_q == S_SLOWAPP) || (state_q == S_ZSEEK);
    wire timedOut = running && msTick && (msCnt_q + 16'd1 >= tmo_q);
    wire zNeeded = (zSel != 4'd2);
    logic originHit, limitAlarm;

    always_comb begin
        state_d = state_q;
        dir_d = dir_q;
        originHit = 1'b0;
        limitAlarm = 1'b0;
        case (state_q)
            S_IDLE, S_DONE, S_FAULT: begin
                if (starting) begin
                    dir_d = modeFwd;
                    state_d = (mode == MODE_PRESENT) ? S_OFFSET : S_SEEK;
                    originHit = (mode == MODE_PRESENT);
                end
            end
            S_SEEK: begin
                if (zMode && zRise) begin
                    originHit = 1'b1;
                    state_d = S_OFFSET;
                end else if (switchMode && switchEdge) begin
                    state_d = zNeeded ? S_ZSEEK : S_SLOWAPP;
                    dir_d = (zSel == 4'd0) ? !dir_q : dir_q;
                end else if (limitHit && !switchMode && !zMode) begin
                    // limit-origin modes treat the alarm variants as 0-2 and never raise the alarm
                    if (limitMode) begin
                        state_d = zNeeded ? S_ZSEEK : S_OFFSET;
                        originHit = !zNeeded;
                        dir_d = (zSel == 4'd0) ? !dir_q : dir_q;
                    end
                end else if (limitHit && limZBase) begin
                    limitAlarm = 1'b1;
                    state_d = S_FAULT;
                end
            end
            S_SLOWAPP: begin
                originHit = 1'b1;
                state_d = S_OFFSET;
            end
            S_ZSEEK: begin
                if (zRise) begin
                    originHit = 1'b1;
                    state_d = S_OFFSET;
                end else if (limitHit && limZBase && !limitMode) begin
                    limitAlarm = 1'b1;
                    state_d = S_FAULT;
                end
            end
            S_OFFSET: begin
                if (offsetMoveDone) state_d = S_DONE;
            end
            default: state_d = S_IDLE;
        endcase
        if (timedOut) state_d = S_FAULT;
    end

    ms_tick #(.CYCLES(CYC_PER_MS)) uTick (
        .sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn), .clear(starting), .tick(msTick)
    );

    logic zAlarm_q, tmoAlarm_q, posLoad_q, offStart_q, complete_q;
    logic [31:0] pos_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= S_IDLE; dir_q <= 1'b1; msCnt_q <= '0;
            firstServo_q <= 1'b0; zAlarm_q <= 1'b0; tmoAlarm_q <= 1'b0;
            posLoad_q <= 1'b0; offStart_q <= 1'b0; complete_q <= 1'b0; pos_q <= '0;
        end else if (clkEn) begin
            state_q <= state_d;
            dir_q <= dir_d;
            if (servoOn_q) firstServo_q <= 1'b1;
            msCnt_q <= starting ? '0 : (msTick ? msCnt_q + 16'd1 : msCnt_q);
            // alarms are sticky until the next run; a new fault in that cycle still wins
            zAlarm_q <= limitAlarm || (zAlarm_q && !starting);
            tmoAlarm_q <= timedOut || (tmoAlarm_q && !starting);
            posLoad_q <= originHit;
            offStart_q <= originHit;
            if (originHit) pos_q <= orgOfs_q;
            complete_q <= (state_q == S_OFFSET && offsetMoveDone) || (complete_q && !starting);
        end
    end
    assign z_pulse_missing_alarm = zAlarm_q;
    assign homing_timeout_alarm = tmoAlarm_q;
    assign positionCount = pos_q;
    assign positionLoad = posLoad_q;
    assign offsetMoveStart = offStart_q;
    assign offsetMoveDist = mechOfs_q;
    assign homingComplete = complete_q;
    wire slowPhase = (state_q == S_ZSEEK) || (state_q == S_SLOWAPP);
    assign motion.active = running;
    assign motion.dirForward = dir_q;
    assign motion.speedRpm = slowPhase ? slow_q : fast_q;
    assign motion.rampMs = ramp_q;

    // ==========================================
    // interrupt positioning and stage 16
    logic lock_q, intStart_q;
    wire [3:0] isel = act_q.intpSel;
    wire trigEdge = (isel == 4'd1 || isel == 4'd2) ? trigRise :
                    (isel == 4'd3 || isel == 4'd4) ? trigFall : 1'b0;
    wire autoRel = (isel == 4'd1) || (isel == 4'd3);
    wire unlock = autoRel ? interruptMoveDone : sense.interruptUnlockInput;
    logic [15:0] wait_q;
    logic waiting_q, waitDone_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_q <= 1'b0; intStart_q <= 1'b0;
            wait_q <= '0; waiting_q <= 1'b0; waitDone_q <= 1'b0;
        end else if (clkEn) begin
            intStart_q <= trigEdge && !lock_q;
            if (trigEdge && !lock_q) lock_q <= 1'b1;
            else if (lock_q && unlock) lock_q <= 1'b0;
            waitDone_q <= 1'b0;
            if (stageDone) begin
                waiting_q <= 1'b1;
                wait_q <= '0;
            end else if (waiting_q && wait_q >= stgWait_q) begin
                waiting_q <= 1'b0;
                waitDone_q <= 1'b1;
            end else if (waiting_q && msTick) begin
                wait_q <= wait_q + 16'd1;
            end
        end
    end
    assign interruptStart = intStart_q;
    assign interruptLocked = lock_q;
    assign stageWaitDone = waitDone_q;

    always_comb begin
        prdata = 32'h0000_0000;
        if (rdAcc) begin
            case (paddr)
                OFS_STG_SPEED: prdata = {16'h0000, stgSpeed_q};
                OFS_STG_RAMP: prdata = {16'h0000, stgRamp_q};
                OFS_STG_WAIT: prdata = {16'h0000, stgWait_q};
                OFS_INTP_SEL: prdata = {28'h000_0000, pend_q.intpSel};
                OFS_HOME_SRC: prdata = {28'h000_0000, pend_q.homeSrc};
                OFS_HOME_MODE: prdata = {28'h000_0000, pend_q.homeMode};
                OFS_LIMZ: prdata = {28'h000_0000, pend_q.limZ};
                OFS_FAST: prdata = {16'h0000, fast_q};
                OFS_SLOW: prdata = {16'h0000, slow_q};
                OFS_RAMP: prdata = {16'h0000, ramp_q};
                OFS_TMO: prdata = {16'h0000, tmo_q};
                OFS_ORG_OFS: prdata = orgOfs_q;
                OFS_MECH_OFS: prdata = mechOfs_q;
                OFS_CTRL: prdata = {30'h0000_0000, servoOn_q, 1'b0};
                OFS_STATUS: prdata = {25'h000_0000, lock_q, tmoAlarm_q, zAlarm_q, complete_q,
                                      running, state_q == S_OFFSET, 1'b0};
                OFS_POS: prdata = pos_q;
                default: prdata = 32'h0000_0000;
            endcase
        end
    end

    // ==========================================
    // checks
    a_timeout_stop: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clkEn && timedOut |=> state_q == S_FAULT && homing_timeout_alarm) else $error("timeout no stop");
    a_present_origin: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clkEn && starting && mode == MODE_PRESENT |=> positionLoad && !motion.active) else $error("mode 8 moved");
    a_origin_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clkEn && originHit |=> positionCount == $past(orgOfs_q)) else $error("bad origin load");
    a_limit_noalarm: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clkEn && limitMode && running && limitHit && !timedOut |=> state_q != S_FAULT) else $error("limit mode stopped");
    a_intp_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
        isel == 4'd0 |=> !interruptStart) else $error("interrupt when off");
    a_intp_edge: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clkEn && isel == 4'd3 && trigFall && !lock_q |=> interruptStart ##0 interruptLocked) else $error("no fall trig");
    a_complete_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clkEn && starting |=> !homingComplete) else $error("complete kept");
    a_fast_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clkEn && starting && mode != MODE_PRESENT |=> motion.speedRpm == fast_q) else $error("not fast");
    a_zalarm: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clkEn && limitAlarm |=> z_pulse_missing_alarm ##0 state_q == S_FAULT) else $error("no z alarm");
    c_home_done: cover property (@(posedge sys_clk) homingComplete);
    c_timeout: cover property (@(posedge sys_clk) homing_timeout_alarm);
    c_intp: cover property (@(posedge sys_clk) interruptStart);
    c_zalarm: cover property (@(posedge sys_clk) z_pulse_missing_alarm);
    c_stage_wait: cover property (@(posedge sys_clk) stageWaitDone);
endmodule

// ===== core/homing_pkg.sv
package homing_pkg;
    localparam int REG_AW = 8;
    localparam logic [7:0] OFS_STG_SPEED = 8'h00;
    localparam logic [7:0] OFS_STG_RAMP = 8'h04;
    localparam logic [7:0] OFS_STG_WAIT = 8'h08;
    localparam logic [7:0] OFS_INTP_SEL = 8'h0C;
    localparam logic [7:0] OFS_HOME_SRC = 8'h10;
    localparam logic [7:0] OFS_HOME_MODE = 8'h14;
    localparam logic [7:0] OFS_LIMZ = 8'h18;
    localparam logic [7:0] OFS_FAST = 8'h1C;
    localparam logic [7:0] OFS_SLOW = 8'h20;
    localparam logic [7:0] OFS_RAMP = 8'h24;
    localparam logic [7:0] OFS_TMO = 8'h28;
    localparam logic [7:0] OFS_ORG_OFS = 8'h2C;
    localparam logic [7:0] OFS_MECH_OFS = 8'h30;
    localparam logic [7:0] OFS_CTRL = 8'h34;
    localparam logic [7:0] OFS_STATUS = 8'h38;
    localparam logic [7:0] OFS_POS = 8'h3C;
    localparam logic [15:0] RST_STG_SPEED = 16'h00C8;
    localparam logic [15:0] RST_STG_RAMP = 16'h000A;
    localparam logic [15:0] RST_STG_WAIT = 16'h0000;
    localparam logic [15:0] RST_INTP_SEL = 16'h0000;
    localparam logic [15:0] RST_HOME_SRC = 16'h0000;
    localparam logic [15:0] RST_HOME_MODE = 16'h0002;
    localparam logic [15:0] RST_LIMZ = 16'h0002;
    localparam logic [15:0] RST_FAST = 16'h01F4;
    localparam logic [15:0] RST_SLOW = 16'h0032;
    localparam logic [15:0] RST_RAMP = 16'h01F4;
    localparam logic [15:0] RST_TMO = 16'hEA60;
    localparam real CLK_MHZ = 20.0;
    localparam int MS_US = 1000;
    localparam int CYC_PER_MS = int'(CLK_MHZ * MS_US);
    localparam logic [1:0] CTRL_START_BIT = 2'd0;
    localparam logic [1:0] CTRL_SERVO_BIT = 2'd1;
    localparam logic [1:0] CTRL_RESTART_BIT = 2'd2;
    localparam logic [3:0] SRC_OFF = 4'h0;
    localparam logic [3:0] SRC_DI = 4'h1;
    localparam logic [3:0] SRC_PANEL = 4'h2;
    localparam logic [3:0] SRC_COMM = 4'h3;
    localparam logic [3:0] SRC_AUTO = 4'h4;
    localparam logic [3:0] MODE_PRESENT = 4'h8;
    localparam logic [3:0] LIMZ_ALARM_BASE = 4'h3;

    typedef struct packed {
        logic posLimit;
        logic negLimit;
        logic homeSwitch;
        logic zPulse;
        logic homingStartInput;
        logic interruptTrigInput;
        logic interruptUnlockInput;
    } sense_t;

    typedef struct packed {
        logic active;
        logic dirForward;
        logic [15:0] speedRpm;
        logic [15:0] rampMs;
    } motion_t;

    typedef struct packed {
        logic [3:0] intpSel;
        logic [3:0] homeSrc;
        logic [3:0] homeMode;
        logic [3:0] limZ;
    } latched_t;
endpackage

// ===== core/ms_tick.sv
`timescale 1ns/1ps
module ms_tick
    import homing_pkg::*;
#(
    parameter int CYCLES = CYC_PER_MS
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic clear,
    output logic tick
);
    logic [$clog2(CYCLES+1)-1:0] cnt_q;
    wire atEnd = (cnt_q == ($clog2(CYCLES+1))'(CYCLES - 1));
    assign tick = clkEn && atEnd && !clear;
    // clear restarts the millisecond phase so a new run gets a full first ms
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (clkEn) begin
            cnt_q <= (clear || atEnd) ? '0 : cnt_q + 1'b1;
        end
    end
endmodule
